// file: osd_char_color_attribute_gen.sv
// Purpose: per-dot colour, luminance and attribute generator of one character cell
// Assumes: one dot per clock; cell inputs come from logic on i_sys_clk
// Notes:   i_vsync is a pin and is synchronised before use
// How it works
// - caption foreground RGB from attr1 bits 1-3
// - normal foreground RGB plus intensity_a, bit 5
// - extended foreground index from attr1 bits 1-3
// - index decoded through eight-entry colour table
// - caption background RGB from attr2 bits 0-2
// - normal background RGBI from attr2 bits 0-3
// - extended background index, same colour table
// - background only where no font, border, extra
// - luma outputs from attr1 bit4, block bits 2,7
// - caption underline on dot rows 23, 24
// - caption flash of font; background flash optional
// - flash 48 periods on, 16 periods off
// - caption italic slants the stored font
// - ratio one: 5 steps; ratio two: 10 half-steps
// - italic slants font, background edge stays vertical
// - neighbours of italic cells are slanted too
// - 32 extra fonts; 16 ORed, 16 alone
// - extended mode selects extra font from attributes
// - select bit4 set only by code 140, blank
// - extra colour register; overlap ORs colours
`timescale 1ns/100ps
module osd_char_color_attribute_gen (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   // register port
   input  wire logic [3:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   // vertical sync pin
   input  wire logic        i_vsync,
   // current dot of the cell
   input  wire logic        i_cell_active,
   input  wire logic [4:0]  i_dot_row,
   input  wire logic [3:0]  i_dot_col,
   input  wire logic        i_sub_dot,
   input  wire logic [7:0]  i_attr1,
   input  wire logic [7:0]  i_attr2,
   input  wire logic [8:0]  i_char_code,
   input  wire logic [15:0] i_font_row,
   input  wire logic [15:0] i_prev_font_row,
   input  wire logic        i_prev_italic,
   input  wire logic        i_next_italic,
   input  wire logic        i_extra_dot,
   input  wire logic        i_border_dot,
   // extra font select
   output logic      [4:0]  o_extra_sel,
   output logic             o_extra_en,
   // colour and luminance outputs
   output logic             o_red,
   output logic             o_green,
   output logic             o_blue,
   output logic             o_intensity_a,
   output logic             o_intensity_b,
   output logic             o_luma_ctl_a,
   output logic             o_luma_ctl_b
);

   // registers
   logic [7:0] disp_ctl;
   logic [7:0] blk_ctl;
   logic [4:0] extra_col;
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         disp_ctl  <= osd_color_pkg::DISP_CTL_RST;
         blk_ctl   <= osd_color_pkg::BLK_CTL_RST;
         extra_col <= osd_color_pkg::EXTRA_COL_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == osd_color_pkg::DISP_CTL_ADDR) disp_ctl <= i_reg_wdata;
         if (i_reg_addr == osd_color_pkg::BLK_CTL_ADDR) blk_ctl <= i_reg_wdata;
         if (i_reg_addr == osd_color_pkg::EXTRA_COL_ADDR) extra_col <= i_reg_wdata[4:0];
      end
   end

   // vsync synchroniser and edge detect
   logic vs_meta;
   logic vs_sync;
   logic vs_last;
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         vs_meta <= 1'b0;
         vs_sync <= 1'b0;
         vs_last <= 1'b0;
      end else begin
         vs_meta <= i_vsync;
         vs_sync <= vs_meta;
         vs_last <= vs_sync;
      end
   end
   wire vs_rise = vs_sync & ~vs_last;

   // one counter for the whole screen keeps every flashing cell in step
   logic [5:0] flash_cnt;
   wire [5:0] next_flash_cnt = (flash_cnt == osd_color_pkg::FLASH_LAST) ? 6'h00
                               : 6'(flash_cnt + 6'h01);
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) flash_cnt <= 6'h00;
      else if (vs_rise) flash_cnt <= next_flash_cnt;
   end
   wire flash_vis = flash_cnt < osd_color_pkg::FLASH_ON_PERIODS;

   // register read, data one cycle later
   wire [7:0] status = {1'b0, flash_vis, flash_cnt};
   wire [7:0] rd_mux = (i_reg_addr == osd_color_pkg::DISP_CTL_ADDR) ? disp_ctl
                     : (i_reg_addr == osd_color_pkg::BLK_CTL_ADDR) ? blk_ctl
                     : (i_reg_addr == osd_color_pkg::EXTRA_COL_ADDR) ? {3'h0, extra_col}
                     : (i_reg_addr == osd_color_pkg::STATUS_ADDR) ? status
                     : 8'h00;
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) o_reg_rdata <= 8'h00;
      else if (i_reg_rd) o_reg_rdata <= rd_mux;
   end

   // mode decode; the unused code behaves as normal mode
   wire [1:0] mode = disp_ctl[osd_color_pkg::MODE_LSB +: 2];
   wire is_cap = mode == osd_color_pkg::caption_display_mode;
   wire is_ext = mode == osd_color_pkg::extended_display_mode;
   wire is_nrm = ~is_cap & ~is_ext;
   wire div2 = blk_ctl[osd_color_pkg::DIV2_BIT];

   // extended colour table, {r,g,b,i1,i2}
   function automatic logic [4:0] ext_color(input logic [2:0] idx);
      case (idx)
         3'h0:    ext_color = 5'h00;
         3'h1:    ext_color = 5'h10;
         3'h2:    ext_color = 5'h08;
         3'h3:    ext_color = 5'h1A;
         3'h4:    ext_color = 5'h19;
         3'h5:    ext_color = 5'h1E;
         3'h6:    ext_color = 5'h0C;
         default: ext_color = 5'h1C;
      endcase
   endfunction

   // foreground colour
   wire [4:0] fg_cap = {i_attr1[1], i_attr1[2], i_attr1[3], 2'b00};
   wire [4:0] fg_nrm = {i_attr1[1], i_attr1[2], i_attr1[3],
                        i_attr1[osd_color_pkg::A1_I1_BIT], 1'b0};
   wire [2:0] fg_idx = i_attr1[3:1];
   wire [4:0] fg_ext = ext_color(fg_idx);
   wire [4:0] fg_col = is_cap ? fg_cap : is_ext ? fg_ext : fg_nrm;

   // background colour
   wire [4:0] bg_cap = {i_attr2[0], i_attr2[1], i_attr2[2], 2'b00};
   wire [4:0] bg_nrm = {i_attr2[0], i_attr2[1], i_attr2[2], i_attr2[3], 1'b0};
   wire [4:0] bg_ext = ext_color(i_attr2[2:0]);
   wire [4:0] bg_col = is_cap ? bg_cap : is_ext ? bg_ext : bg_nrm;

   // italic offset in half dots, larger toward the top row
   function automatic logic [4:0] ital_off(input logic [4:0] row, input logic half);
      int up;
      up = (row >= osd_color_pkg::CELL_ROWS) ? 0 : 26 - int'(row);
      if (half) ital_off = 5'((up * osd_color_pkg::ITAL_STEPS_2) / 26);
      else ital_off = 5'(2 * ((up * osd_color_pkg::ITAL_STEPS_1) / 26));
   endfunction
   wire ital_own = is_cap & i_attr1[osd_color_pkg::A1_ITAL_BIT];
   wire ital_eff = ital_own | (is_cap & (i_prev_italic | i_next_italic));
   wire [4:0] off_half = ital_eff ? ital_off(i_dot_row, div2) : 5'h00;
   // font may spill in from the left cell, so both rows are needed
   wire [31:0] font_pair = {i_prev_font_row, i_font_row};
   wire [6:0] pos_half = 7'h20 + {2'b00, i_dot_col, 1'b0} + {6'h00, div2 & i_sub_dot}
                         - {2'b00, off_half};
   wire [4:0] dot_idx = 5'h1F - pos_half[5:1];
   // code 140 has no font and shows blank
   wire blank_code = i_char_code == osd_color_pkg::BLANK_CODE;
   wire font_dot = i_cell_active & ~blank_code & font_pair[dot_idx];

   // underline
   wire ul_row = (i_dot_row == osd_color_pkg::UL_ROW_A) | (i_dot_row == osd_color_pkg::UL_ROW_B);
   wire ul_dot = i_cell_active & is_cap & i_attr1[osd_color_pkg::A1_UL_BIT] & ul_row;

   // flash
   wire fl_on = is_cap & i_attr1[osd_color_pkg::A1_FLASH_BIT] & ~flash_vis;
   wire fg_blank = fl_on;
   wire bg_blank = fl_on & disp_ctl[osd_color_pkg::BG_FLASH_BIT];
   wire fg_dot = (font_dot | ul_dot) & ~fg_blank;

   // extra font
   wire ex4 = blank_code;
   wire [4:0] ex_sel = {ex4, i_attr2[osd_color_pkg::A2_EX3_BIT], i_attr1[7:5]};
   wire ex_dot = is_ext & i_cell_active & i_extra_dot;
   // lower 16 patterns overlay the character, upper 16 replace it
   wire ex_alone = ex_sel[4];
   wire fg_show = fg_dot & ~(ex_dot & ex_alone);

   // border area
   wire brd_dot = ~is_cap & blk_ctl[osd_color_pkg::BORDER_BIT] & i_border_dot;

   // colour priority
   wire [4:0] fg_part = fg_show ? fg_col : 5'h00;
   wire [4:0] ex_part = ex_dot ? extra_col : 5'h00;
   wire covered = fg_show | ex_dot | brd_dot | (font_dot & ~fg_blank);
   wire bg_dot = i_cell_active & ~covered & ~bg_blank;
   wire [4:0] next_color = bg_dot ? bg_col : (fg_part | ex_part);

   // luminance controls
   wire area = i_cell_active & ~bg_blank;
   wire luma_sel = blk_ctl[osd_color_pkg::LUMA_SEL_BIT];
   wire a1_luma = i_attr1[osd_color_pkg::A1_LUMA_BIT];
   wire next_luma_a = ((~luma_sel & a1_luma) ? area : fg_show) | brd_dot;
   wire next_luma_b = luma_sel & a1_luma & area;

   // registered outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         {o_red, o_green, o_blue, o_intensity_a, o_intensity_b} <= 5'h00;
         o_luma_ctl_a <= 1'b0;
         o_luma_ctl_b <= 1'b0;
         o_extra_sel  <= 5'h00;
         o_extra_en   <= 1'b0;
      end else begin
         {o_red, o_green, o_blue, o_intensity_a, o_intensity_b} <= next_color;
         o_luma_ctl_a <= next_luma_a;
         o_luma_ctl_b <= next_luma_b;
         o_extra_sel  <= ex_sel;
         o_extra_en   <= is_ext;
      end
   end

   // checks
   wire [4:0] out_col = {o_red, o_green, o_blue, o_intensity_a, o_intensity_b};

   a_caption_fg: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (fg_show & ~ex_dot & ~bg_dot & is_cap) |=>
      out_col == {$past(i_attr1[1]), $past(i_attr1[2]), $past(i_attr1[3]), 2'b00})
      else $error("caption foreground colour wrong");

   a_normal_fg: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (fg_show & ~ex_dot & is_nrm) |=> out_col[1] == $past(i_attr1[5]) && !out_col[0])
      else $error("normal foreground intensity wrong");

   a_ext_decode: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (fg_show & ~ex_dot & is_ext & (fg_idx == 3'h4)) |=> out_col == 5'h19)
      else $error("extended index 4 not red green intensity_b");

   a_bg_only: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_cell_active & ((font_dot & ~fg_blank) | brd_dot) & ~fg_show & ~ex_dot) |=>
      out_col == 5'h00)
      else $error("background mixed with covered dot");

   a_underline_row: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (ul_dot & ~fg_blank & is_cap & (i_attr1[3:1] == 3'h7) & ~ex_dot) |=> o_red & o_blue)
      else $error("underline dot not drawn");

   sequence flash_wrap_s;
      vs_rise && flash_cnt == osd_color_pkg::FLASH_LAST;
   endsequence
   sequence flash_start_s;
      flash_cnt == 6'h00 && flash_vis;
   endsequence
   a_flash_wrap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      flash_wrap_s |=> flash_start_s)
      else $error("flash counter did not wrap after 64 periods");

   a_flash_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (vs_rise && flash_cnt == 6'h2F) |=> !flash_vis)
      else $error("flash visible phase not 48 periods");

   a_blank_code: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_cell_active & blank_code & ~ul_dot & ~ex_dot & ~brd_dot & ~bg_blank) |=>
      out_col == $past(bg_col))
      else $error("code 140 not blank");

   a_extra_or: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (ex_dot & fg_show) |=> out_col == ($past(fg_col) | $past(extra_col)))
      else $error("overlap colour not ORed");

   a_luma_b: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (~luma_sel) |=> !o_luma_ctl_b)
      else $error("luma_ctl_b active without block select");

   a_italic_span: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (~ital_eff) |-> off_half == 5'h00)
      else $error("upright cell has slant");

endmodule // osd_char_color_attribute_gen

// file: osd_char_color_attribute_gen_tb.sv
// Purpose: self-checking bench for the character colour generator
// Assumes: one dot per clock, registers reached over the plain port
// Notes:   sub-dot input stays low; italic is checked on dot row 1 only
`timescale 1ns/100ps
module osd_char_color_attribute_gen_tb;
   localparam logic [4:0] EXT_TAB [8] = '{5'h00, 5'h10, 5'h08, 5'h1A, 5'h19, 5'h1E, 5'h0C, 5'h1C};
   logic        clk, rst, wr, rd, act, sub, pit, nit, xd, bd, vs_start, vis;
   logic [3:0]  addr, col;
   logic [4:0]  row, xcol, ec;
   logic [7:0]  wd, a1, a2, disp, blk, vs_n, rv;
   logic [8:0]  code;
   logic [15:0] fr, pfr;
   logic [1:0]  el;
   wire  [7:0]  rdata;
   wire  [4:0]  xsel;
   wire         xen, r, g, b, ia, ib, la, lb, vsync, vs_busy;
   int          error_cnt, checks, seed;
   osd_char_color_attribute_gen u_osd_char_color_attribute_gen (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_vsync(vsync),
      .i_cell_active(act), .i_dot_row(row), .i_dot_col(col), .i_sub_dot(sub),
      .i_attr1(a1), .i_attr2(a2), .i_char_code(code), .i_font_row(fr),
      .i_prev_font_row(pfr), .i_prev_italic(pit), .i_next_italic(nit),
      .i_extra_dot(xd), .i_border_dot(bd), .o_extra_sel(xsel), .o_extra_en(xen),
      .o_red(r), .o_green(g), .o_blue(b), .o_intensity_a(ia), .o_intensity_b(ib),
      .o_luma_ctl_a(la), .o_luma_ctl_b(lb));
   vsync_source u_vsync_source (.i_sys_clk(clk), .i_count(vs_n), .i_start(vs_start),
      .o_vsync(vsync), .o_busy(vs_busy));
   // fixed dot rate; picking 11-14 MHz for ratio-one italic is software's job
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic cmp_color(input logic [4:0] gv, input logic [4:0] ev);
      chk(gv === ev, "colour outputs differ");
   endtask
   task automatic cmp_luma(input logic [1:0] gv, input logic [1:0] ev);
      chk(gv === ev, "luminance outputs differ");
   endtask
   task automatic cmp_sel(input logic [5:0] gv, input logic [5:0] ev);
      chk(gv === ev, "extra font select differs");
   endtask
   task automatic cmp_reg(input logic [7:0] gv, input logic [7:0] ev);
      chk(gv === ev, "register read differs");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // reference for one dot; called at the edge that samples the dot
   function automatic void model();
      int sh;
      int src;
      logic cap, ext, fp, off, bon, ar;
      logic [4:0] fg, bg;
      cap = (disp[1:0] == 2'b00);
      ext = (disp[1:0] == 2'b10);
      fg = ext ? EXT_TAB[a1[3:1]] : {a1[1], a1[2], a1[3], !cap & a1[5], 1'b0};
      bg = ext ? EXT_TAB[a2[2:0]] : {a2[0], a2[1], a2[2], !cap & a2[3], 1'b0};
      sh = 0;
      if (cap && (a1[7] || pit || nit))
         sh = blk[0] ? (26 - int'(row)) * 10 / 26 : 2 * ((26 - int'(row)) * 5 / 26);
      src = 2 * int'(col) + int'(sub) - sh;
      fp = (src >= 0) ? fr[15 - src / 2] : pfr[15 - (src + 32) / 2];
      off = cap & a1[5] & !vis;
      fp = (fp | (cap & a1[6] & (row == 5'h17 || row == 5'h18))) & !off;
      bon = bd & blk[2] & !cap;
      if (!act) ec = 5'h00;
      else if (ext && xd) ec = (fp && code != 9'h140) ? (fg | xcol) : xcol;
      else if (fp) ec = fg;
      else if (bon || (off && disp[3])) ec = 5'h00;
      else ec = bg;
      ar = act & !(off & disp[3]);
      el = {(blk[7] ? fp : (a1[4] ? ar : fp)) | bon, blk[7] & a1[4] & ar};
      // border reaches past the cell, so it still drives luma_ctl_a there
      if (!act) el = {bon, 1'b0};
   endfunction
   task automatic step();
      @(posedge clk);
      model();
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic cfg(input logic [7:0] d, input logic [7:0] k);
      reg_wr(osd_color_pkg::DISP_CTL_ADDR, d);
      reg_wr(osd_color_pkg::BLK_CTL_ADDR, k);
      disp = d;
      blk = k;
   endtask
   task automatic vpulses(input logic [7:0] n);
      @(posedge clk);
      vs_n <= n;
      vs_start <= 1'b1;
      @(posedge clk);
      vs_start <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4000 && vs_busy; i++) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask
   initial begin
      #500000;
      error_cnt++;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      seed = 32'hfd0774bd;
      {rst, wr, rd, act, sub, pit, nit, xd, bd, vs_start, vis} = 11'h401;
      {addr, col, row, xcol, wd, a1, a2, disp, blk, vs_n, code, fr, pfr} = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         reg_rd(i == 4 ? 4'hF : 4'(i));
         cmp_reg(rv, i == 3 ? 8'h40 : 8'h00);
      end
      reg_wr(osd_color_pkg::STATUS_ADDR, 8'hFF);
      reg_wr(4'hF, 8'hFF);
      reg_wr(osd_color_pkg::EXTRA_COL_ADDR, 8'h05);
      xcol = 5'h05;
      for (int i = 1; i < 4; i++) begin
         reg_rd(i == 1 ? 4'hF : 4'(i));
         cmp_reg(rv, i == 2 ? 8'h05 : (i == 3 ? 8'h40 : 8'h00));
      end
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         cfg({6'h00, m[1:0]}, {m[2], 4'h0, 1'b1, 2'b00}); // blk bit 7 from m[2]; blk bits 6-3, 1, 0 kept clear
         for (int k = 0; k < 16; k++) begin
            logic [8:0] cd;
            cd = 9'({$random(seed)} % 321);
            @(posedge clk);
            act <= (k % 4) != 0;
            row <= 5'(1 + {$random(seed)} % 22);
            col <= 4'($random(seed));
            a1 <= 8'($random(seed)) & 8'h7F;
            a2 <= 8'($random(seed));
            code <= cd;
            fr <= (cd == 9'h140) ? 16'h0000 : 16'($random(seed));
            pfr <= 16'($random(seed));
            xd <= 1'($random(seed));
            bd <= 1'($random(seed));
            step();
            cmp_color({r, g, b, ia, ib}, ec);
            if (!(disp[1:0] == 2'b10 && xd)) cmp_luma({la, lb}, el);
            cmp_sel({xen, m[1:0] == 2 ? xsel : 5'h00},
                    m[1:0] == 2 ? {1'b1, code == 9'h140, a2[3], a1[7:5]} : 6'h00);
         end
      end
      $display("test random dots done");
      cfg(8'h02, 8'h00);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         {act, xd, bd, code} <= 12'h800;
         a1 <= {4'h0, i[2:0], 1'b0};
         a2 <= {5'h00, i[2:0]};
         fr <= i[3] ? 16'hFFFF : 16'h0000;
         step();
         cmp_color({r, g, b, ia, ib}, ec);
      end
      $display("test colour tables done");
      for (int i = 0; i < 68; i++) begin
         if (i % 32 == 0) cfg(8'h00, 8'(i / 32) & 8'h01);
         @(posedge clk);
         row <= (i < 64) ? 5'h01 : 5'(i - 42);
         col <= 4'(i);
         a1 <= (i >= 64) ? 8'h42 : (i[4] ? 8'h02 : 8'h82);
         nit <= (i < 64) && i[4];
         a2 <= 8'h04;
         fr <= (i < 64) ? 16'h8000 : 16'h0000;
         pfr <= (i < 64) ? 16'h0001 : 16'h0000;
         step();
         cmp_color({r, g, b, ia, ib}, ec);
      end
      $display("test italic and underline done");
      cfg(8'h08, 8'h00);
      nit <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         vpulses(p == 0 ? 8'h00 : (p == 1 ? 8'h30 : 8'h10));
         vis = (p != 1);
         reg_rd(osd_color_pkg::STATUS_ADDR);
         cmp_reg(rv, vis ? 8'h40 : 8'h30);
         for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            a1 <= (i == 2) ? 8'h02 : 8'h22;
            col <= (i == 1) ? 4'hF : 4'h0;
            fr <= 16'hFF00;
            step();
            cmp_color({r, g, b, ia, ib}, ec);
            cmp_luma({la, lb}, el);
         end
      end
      $display("test flash done");
      tally_and_finish();
   end
endmodule // osd_char_color_attribute_gen_tb

// file: osd_color_pkg.sv
// Purpose: constants for the per-character colour and attribute generator
// Assumes: one dot per clock, 8-bit register port
// Notes:   colour vectors are ordered {r, g, b, intensity_a, intensity_b}
package osd_color_pkg;
   // register offsets
   localparam logic [3:0] DISP_CTL_ADDR  = 4'h0;
   localparam logic [3:0] BLK_CTL_ADDR   = 4'h1;
   localparam logic [3:0] EXTRA_COL_ADDR = 4'h2;
   localparam logic [3:0] STATUS_ADDR    = 4'h3;
   // reset values
   localparam logic [7:0] DISP_CTL_RST  = 8'h00;
   localparam logic [7:0] BLK_CTL_RST   = 8'h00;
   localparam logic [4:0] EXTRA_COL_RST = 5'h00;
   // display control fields
   localparam int MODE_LSB     = 0;
   localparam int BG_FLASH_BIT = 3;
   // block control fields
   localparam int DIV2_BIT     = 0;
   localparam int BORDER_BIT   = 2;
   localparam int LUMA_SEL_BIT = 7;
   // first attribute byte fields
   localparam int A1_LUMA_BIT  = 4;
   localparam int A1_I1_BIT    = 5;
   localparam int A1_FLASH_BIT = 5;
   localparam int A1_UL_BIT    = 6;
   localparam int A1_ITAL_BIT  = 7;
   // second attribute byte fields
   localparam int A2_EX3_BIT   = 3;
   // display modes
   typedef enum logic [1:0] {
      caption_display_mode  = 2'b00,
      normal_display_mode   = 2'b01,
      extended_display_mode = 2'b10
   } disp_mode_t;
   // cell geometry
   localparam logic [4:0] CELL_ROWS = 5'h1A;
   localparam logic [4:0] UL_ROW_A  = 5'h17;
   localparam logic [4:0] UL_ROW_B  = 5'h18;
   localparam int ITAL_STEPS_1 = 5;
   localparam int ITAL_STEPS_2 = 10;
   // extra font
   localparam logic [8:0] BLANK_CODE = 9'h140;
   // flash timing in vertical sync periods
   localparam logic [5:0] FLASH_ON_PERIODS  = 6'h30;
   localparam logic [5:0] FLASH_OFF_PERIODS = 6'h10;
   localparam logic [5:0] FLASH_LAST = 6'(FLASH_ON_PERIODS + FLASH_OFF_PERIODS - 6'h01);
endpackage

// file: vsync_source.sv
// Purpose: vertical sync source standing in for the video side
// Assumes: one pulse train per request, started while idle
// Notes:   pulses are 4 cycles high and 4 low; pin rests low between trains
`timescale 1ns/100ps
module vsync_source (
   // clock
   input  wire logic       i_sys_clk,
   // request
   input  wire logic [7:0] i_count,
   input  wire logic       i_start,
   // sync pin and status
   output logic            o_vsync,
   output logic            o_busy
);
   int left = 0;
   int ph   = 0;
   always_ff @(posedge i_sys_clk) begin
      if (i_start && left == 0) begin
         left <= int'(i_count);
         ph <= 0;
      end else if (left != 0) begin
         ph <= (ph + 1) % 8;
         if (ph == 7) left <= left - 1;
      end
   end
   assign o_vsync = (left != 0) && (ph < 4);
   assign o_busy  = (left != 0);
endmodule // vsync_source
